// file: rtl/upx_pkg.sv
// upx_pkg: constants and carrier types for the universal parameter access proxy.
// assumes one 125 MHz system clock shared by the host register port and the drive port.
package upx_pkg;

  // register indices on the host register port
  localparam logic [15:0] UPX_IDX_TARGET = 16'h0064;
  localparam logic [15:0] UPX_IDX_VALUE  = 16'h0065;
  localparam logic [15:0] UPX_IDX_STATUS = 16'h0066;

  // reset values
  localparam logic [15:0] UPX_TARGET_RST = 16'h0000;
  localparam logic [15:0] UPX_VALUE_RST  = 16'h0000;
  localparam logic [15:0] UPX_STATUS_RST = 16'h00ff;

  // status field positions inside proxy_access_status
  localparam int UPX_RD_LSB = 0;
  localparam int UPX_WR_LSB = 8;

  // outcome codes shared by read and write status bytes
  localparam logic [7:0] UPX_CODE_OK        = 8'h00;
  localparam logic [7:0] UPX_CODE_BAD_PARAM = 8'h02;
  localparam logic [7:0] UPX_CODE_BAD_DATA  = 8'h03;
  localparam logic [7:0] UPX_CODE_LINK_LOST = 8'h07;
  localparam logic [7:0] UPX_CODE_OTHER     = 8'h0a;
  localparam logic [7:0] UPX_CODE_NOT_READY = 8'hff;
  localparam logic [7:0] UPX_CODE_PENDING   = 8'hff;
  localparam logic [7:0] UPX_WR_IDLE        = 8'h00;

  // host register port request
  typedef struct packed {
    logic        we;
    logic        re;
    logic [15:0] idx;
    logic [15:0] wdata;
  } upx_host_req_t;

  // request toward the drive parameter interface
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] param;
    logic [15:0] wdata;
  } upx_drv_req_t;

  // answer from the drive parameter interface
  typedef struct packed {
    logic        ack;
    logic [7:0]  code;
    logic [15:0] rdata;
  } upx_drv_rsp_t;

  typedef enum logic [0:0] {
    UPX_ST_IDLE = 1'b0,
    UPX_ST_BUSY = 1'b1
  } upx_seq_state_t;

endpackage

// file: rtl/upx_drive_seq.sv
// upx_drive_seq: runs one drive parameter transaction at a time, writes before reads.
// assumes the drive answers with a one-cycle ack on the same clock.
`timescale 1ns/1ps
`default_nettype none
module upx_drive_seq
  import upx_pkg::*;
(
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  // work requests from the register side
  input  wire logic         wr_want_i,
  input  wire logic         rd_want_i,
  input  wire logic         abort_i,
  input  wire logic [15:0]  param_i,
  input  wire logic [15:0]  wdata_i,
  output logic              wr_launch_o,
  // completion report
  output logic              done_o,
  output logic              done_wr_o,
  output logic [7:0]        done_code_o,
  output logic [15:0]       done_rdata_o,
  // drive parameter interface
  output var upx_drv_req_t  drv_req_o,
  input  wire upx_drv_rsp_t drv_rsp_i
);

  upx_seq_state_t state_r;
  logic           stale_r;
  logic           launch_ok;

  // no launch in the cycle the selection changes
  assign launch_ok   = (state_r == UPX_ST_IDLE) && !abort_i;
  assign wr_launch_o = launch_ok && wr_want_i;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r   <= UPX_ST_IDLE;
      drv_req_o <= '0;
    end
    else
    begin
      case (state_r)
        UPX_ST_IDLE:
        begin
          if (launch_ok && (wr_want_i || rd_want_i))
          begin
            drv_req_o <= '{req: 1'b1, we: wr_want_i, param: param_i, wdata: wdata_i};
            state_r   <= UPX_ST_BUSY;
          end
        end
        UPX_ST_BUSY:
        begin
          if (drv_rsp_i.ack)
          begin
            drv_req_o.req <= 1'b0;
            state_r       <= UPX_ST_IDLE;
          end
        end
        default:
        begin
          state_r   <= UPX_ST_IDLE;
          drv_req_o <= '0;
        end
      endcase
    end
  end

  // an answer for a selection that has since changed is dropped
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      stale_r <= 1'b0;
    else if (state_r == UPX_ST_IDLE)
      stale_r <= 1'b0;
    else if (abort_i)
      stale_r <= 1'b1;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      done_o       <= 1'b0;
      done_wr_o    <= 1'b0;
      done_code_o  <= UPX_CODE_OK;
      done_rdata_o <= UPX_VALUE_RST;
    end
    else
    begin
      done_o <= (state_r == UPX_ST_BUSY) && drv_rsp_i.ack && !stale_r && !abort_i;
      if ((state_r == UPX_ST_BUSY) && drv_rsp_i.ack)
      begin
        done_wr_o    <= drv_req_o.we;
        done_code_o  <= drv_rsp_i.code;
        done_rdata_o <= drv_rsp_i.rdata;
      end
    end
  end

  a_single_txn_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (drv_req_o.req && !drv_rsp_i.ack) |=> (drv_req_o.req && $stable(drv_req_o)))
    else $error("drive request changed before its ack");

  a_write_first: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_r == UPX_ST_IDLE && wr_want_i && rd_want_i && !abort_i) |=> (drv_req_o.req && drv_req_o.we))
    else $error("pending write did not take priority over read");

endmodule
`default_nettype wire

// file: rtl/upx_proxy.sv
// upx_proxy: indirect parameter access proxy with target select, value port and status.
// assumes a same-clock host register port and a drive parameter interface with one-cycle ack.
// How it works
// - writing the value port sets write status to pending 0xff at once
// - write completion replaces pending with its outcome code: 00, 02, 03, 07, 0a
// - the write outcome code is held in place of the pending code
// - after a write, reads of the selected parameter resume continuously
// - write status only changes on a new value write, a write completion or a target change
// - a failed write is never retried; only a new host write retries
// - on read success the value port holds and keeps refreshing the parameter value
// - a failed read is retried continuously while the target stays unchanged
// - target zero disables: value reads zero, status reads 0x00ff
// - reset leaves target zero, value zero, status 0x00ff
// - status carries read status in low byte, write status in high byte
// - writing the target clears the value and sets read status not ready
// - read codes: 00 ok, 02 bad parameter, 07 link lost, 0a other, ff not ready
`timescale 1ns/1ps
`default_nettype none
module upx_proxy
  import upx_pkg::*;
(
  // clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          rst_n_i,
  // host register port
  input  wire upx_host_req_t host_req_i,
  output logic [15:0]        host_rdata_o,
  output logic               host_rvalid_o,
  // drive parameter interface
  output var upx_drv_req_t   drv_req_o,
  input  wire upx_drv_rsp_t  drv_rsp_i
);

  logic [15:0] target_r;
  logic [15:0] value_r;
  logic [15:0] wdata_r;
  logic [7:0]  rd_stat_r;
  logic [7:0]  wr_stat_r;
  logic        wr_want_r;

  logic        tgt_wr;
  logic        val_wr;
  logic        enabled;
  logic        wr_launch;
  logic        done;
  logic        done_wr;
  logic [7:0]  done_code;
  logic [15:0] done_rdata;
  logic [15:0] status;

  assign enabled = (target_r != UPX_TARGET_RST);
  assign tgt_wr  = host_req_i.we && (host_req_i.idx == UPX_IDX_TARGET);
  assign val_wr  = host_req_i.we && (host_req_i.idx == UPX_IDX_VALUE) && enabled;
  assign status  = {wr_stat_r, rd_stat_r};

  upx_drive_seq u_seq (
    .sys_clk_i    (sys_clk_i),
    .rst_n_i      (rst_n_i),
    .wr_want_i    (wr_want_r),
    .rd_want_i    (enabled),
    .abort_i      (tgt_wr),
    .param_i      (target_r),
    .wdata_i      (wdata_r),
    .wr_launch_o  (wr_launch),
    .done_o       (done),
    .done_wr_o    (done_wr),
    .done_code_o  (done_code),
    .done_rdata_o (done_rdata),
    .drv_req_o    (drv_req_o),
    .drv_rsp_i    (drv_rsp_i)
  );

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      target_r <= UPX_TARGET_RST;
    else if (tgt_wr)
      target_r <= host_req_i.wdata;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      value_r <= UPX_VALUE_RST;
    else if (tgt_wr)
      value_r <= UPX_VALUE_RST;
    else if (val_wr)
      value_r <= host_req_i.wdata;
    else if (done && !done_wr && (done_code == UPX_CODE_OK))
      value_r <= done_rdata;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rd_stat_r <= UPX_STATUS_RST[UPX_RD_LSB +: 8];
    else if (tgt_wr)
      rd_stat_r <= UPX_CODE_NOT_READY;
    else if (done && !done_wr)
      rd_stat_r <= done_code;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wr_stat_r <= UPX_STATUS_RST[UPX_WR_LSB +: 8];
    else if (tgt_wr)
      wr_stat_r <= UPX_WR_IDLE;
    else if (val_wr)
      wr_stat_r <= UPX_CODE_PENDING;
    else if (done && done_wr && !wr_want_r)
      wr_stat_r <= done_code;
  end

  // want is cleared at launch, so a failed write is not sent again
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wr_want_r <= 1'b0;
    else if (tgt_wr)
      wr_want_r <= 1'b0;
    else if (val_wr)
      wr_want_r <= 1'b1;
    else if (wr_launch)
      wr_want_r <= 1'b0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wdata_r <= UPX_VALUE_RST;
    else if (val_wr)
      wdata_r <= host_req_i.wdata;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      host_rdata_o  <= '0;
      host_rvalid_o <= 1'b0;
    end
    else
    begin
      host_rvalid_o <= host_req_i.re;
      if (host_req_i.re)
      begin
        case (host_req_i.idx)
          UPX_IDX_TARGET: host_rdata_o <= target_r;
          UPX_IDX_VALUE:  host_rdata_o <= value_r;
          UPX_IDX_STATUS: host_rdata_o <= status;
          default:        host_rdata_o <= '0;
        endcase
      end
    end
  end

  a_pending_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    val_wr |=> (wr_stat_r == 8'hff))
    else $error("value write did not set write pending");

  a_write_outcome: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (done && done_wr && !wr_want_r && !tgt_wr && !val_wr) |=> (wr_stat_r == $past(done_code)))
    else $error("write outcome not reported");

  a_wr_stat_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!tgt_wr && !val_wr && !(done && done_wr)) |=> $stable(wr_stat_r))
    else $error("write status changed without cause");

  a_no_retry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (done && done_wr && (done_code != 8'h00) && !val_wr && !wr_want_r) |=> !wr_want_r)
    else $error("failed write was queued again");

  a_read_refresh: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (done && !done_wr && (done_code == 8'h00) && !tgt_wr && !val_wr) |=> (value_r == $past(done_rdata)))
    else $error("value not refreshed from read");

  a_read_retry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (enabled && !drv_req_o.req && !tgt_wr) |=> drv_req_o.req)
    else $error("background read not reissued");

  a_disabled_view: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !enabled |-> (value_r == 16'h0000 && status == 16'h00ff))
    else $error("disabled proxy shows wrong value or status");

  a_reset_view: assert property (@(posedge sys_clk_i)
    $rose(rst_n_i) |-> (target_r == 16'h0000 && value_r == 16'h0000 && status == 16'h00ff))
    else $error("reset state wrong");

  a_status_pack: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (host_req_i.re && host_req_i.idx == UPX_IDX_STATUS) |=> (host_rdata_o == $past(status)))
    else $error("status read does not pack read and write bytes");

  a_target_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tgt_wr |=> (value_r == 16'h0000 && rd_stat_r == 8'hff))
    else $error("target write did not clear value and read status");

  a_ignore_disabled: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (host_req_i.we && host_req_i.idx == UPX_IDX_VALUE && !enabled && !tgt_wr) |=> !wr_want_r)
    else $error("value write accepted while disabled");

  a_read_code: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (done && !done_wr && !tgt_wr) |=> (rd_stat_r == $past(done_code)))
    else $error("read outcome code not reported");

  a_read_target: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(drv_req_o.req) |-> (drv_req_o.param == target_r))
    else $error("drive request aims at a stale target");

  a_disabled_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!enabled && !drv_req_o.req) |=> !drv_req_o.req)
    else $error("drive request issued while disabled");

  a_new_attempt: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    val_wr |=> (wr_want_r && wdata_r == $past(host_req_i.wdata)))
    else $error("host value write did not start a new attempt");

endmodule
`default_nettype wire

// file: dv/upx_drive_model.sv
// upx_drive_model: behavioural drive parameter port for the proxy bench.
// assumes one clock; answer delay and codes are set by the bench.
`timescale 1ns/1ps
`default_nettype none
module upx_drive_model
  import upx_pkg::*;
(
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  // answer shaping
  input  wire logic [3:0]   dly_i,
  input  wire logic [7:0]   rd_code_i,
  input  wire logic [7:0]   wr_code_i,
  // drive parameter interface
  input  wire upx_drv_req_t drv_req_i,
  output var upx_drv_rsp_t  drv_rsp_o
);
  logic [3:0]  cnt_r;
  logic [15:0] store_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r     <= 4'h0;
      store_r   <= 16'h5a3c;
      drv_rsp_o <= '0;
    end
    else if (drv_req_i.req && !drv_rsp_o.ack && cnt_r == dly_i)
    begin
      cnt_r     <= 4'h0;
      drv_rsp_o <= '{1'b1, drv_req_i.we ? wr_code_i : rd_code_i, store_r};
      if (drv_req_i.we && wr_code_i == 8'h00)
        store_r <= drv_req_i.wdata;
    end
    else
    begin
      // idle answer lines toggle so stale data is never taken for a result
      cnt_r     <= (drv_req_i.req && !drv_rsp_o.ack) ? cnt_r + 4'h1 : 4'h0;
      drv_rsp_o <= '{1'b0, ~drv_rsp_o.code, ~drv_rsp_o.rdata};
    end
  end
endmodule
`default_nettype wire

// file: dv/upx_proxy_tb.sv
// upx_proxy_tb: self-checking bench for the parameter access proxy.
// assumes the drive model answers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module upx_proxy_tb
  import upx_pkg::*;
;
  typedef struct {string nm; logic [15:0] e; bit chk;} upx_note_t;
  logic          clk;
  logic          rst_n;
  upx_host_req_t host_req;
  logic [15:0]   host_rdata;
  logic          host_rvalid;
  upx_drv_req_t  drv_req;
  upx_drv_rsp_t  drv_rsp;
  logic [3:0]    dly;
  logic [7:0]    rd_code;
  logic [7:0]    wr_code;
  logic [15:0]   rd_last;
  logic [15:0]   exp_param;
  logic [15:0]   exp_wdata;
  logic          req_q;
  int            errors;
  int            cmp_count;
  int            n_rd;
  int            n_wr;
  upx_note_t     note;
  upx_note_t     notes[$];
  logic [7:0]    wcodes[5] = '{8'h00, 8'h02, 8'h03, 8'h07, 8'h0a};
  logic [7:0]    rcodes[4] = '{8'h02, 8'h07, 8'h0a, 8'h00};

  upx_proxy dut (.sys_clk_i(clk), .rst_n_i(rst_n), .host_req_i(host_req), .host_rdata_o(host_rdata),
    .host_rvalid_o(host_rvalid), .drv_req_o(drv_req), .drv_rsp_i(drv_rsp));
  upx_drive_model model (.sys_clk_i(clk), .rst_n_i(rst_n), .dly_i(dly), .rd_code_i(rd_code),
    .wr_code_i(wr_code), .drv_req_i(drv_req), .drv_rsp_o(drv_rsp));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    @(negedge clk);
    host_req = '{1'b1, 1'b0, idx, d};
    @(negedge clk);
    host_req = '0;
  endtask

  task automatic rd(input logic [15:0] idx, input logic [15:0] e, input bit chk);
    @(negedge clk);
    host_req = '{1'b0, 1'b1, idx, 16'h0000};
    notes.push_back('{$sformatf("reg_%0d", idx), e, chk});
    @(negedge clk);
    host_req = '0;
  endtask

  task automatic poll(input int sh, output logic [7:0] b);
    b = 8'hff;
    for (int i = 0; i < 100; i++)
    begin
      rd(UPX_IDX_STATUS, 16'h0000, 1'b0);
      @(negedge clk);
      b = rd_last[sh +: 8];
      if (b !== 8'hff)
        break;
    end
    // a status byte stuck at ff past the limit is a failure
    if (b === 8'hff)
    begin
      errors++;
      $display("[ERR] poll_limit expected not ff seen %h", b);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(negedge clk)
    if (host_rvalid === 1'b1 && notes.size() > 0)
    begin
      note = notes.pop_front();
      rd_last = host_rdata;
      if (note.chk)
        cmp16(note.nm, note.e, host_rdata);
    end

  always @(posedge clk)
    if (drv_req.req === 1'b1 && drv_rsp.ack === 1'b1)
      if (drv_req.we)
        n_wr++;
      else
        n_rd++;

  // each new drive request must aim at the selected target; a write request must also carry the last written value
  always @(posedge clk)
  begin
    req_q <= drv_req.req;
    if (drv_req.req === 1'b1 && req_q !== 1'b1)
    begin
      cmp16("drv_param", exp_param, drv_req.param);
      if (drv_req.we === 1'b1)
        cmp16("drv_wdata", exp_wdata, drv_req.wdata);
    end
  end

  initial
  begin
    #400000;
    errors++;
    print_verdict();
  end

  initial
  begin
    logic [15:0] tgt;
    logic [15:0] v;
    logic [15:0] exp_v;
    logic [7:0]  b;
    int          n;
    host_req = '0;
    rst_n = 1'b0;
    dly = 4'h2;
    rd_code = 8'h00;
    wr_code = 8'h00;
    errors = 0;
    cmp_count = 0;
    n_rd = 0;
    n_wr = 0;
    rd_last = 16'h0000;
    exp_param = 16'h0000;
    exp_wdata = 16'h0000;
    exp_v = 16'h5a3c;
    void'($urandom(37));
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rd(UPX_IDX_TARGET, 16'h0000, 1'b1);
    rd(UPX_IDX_VALUE, 16'h0000, 1'b1);
    rd(UPX_IDX_STATUS, 16'h00ff, 1'b1);
    rd(16'h0067, 16'h0000, 1'b1);
    wr(UPX_IDX_VALUE, 16'h1234);
    rd(UPX_IDX_VALUE, 16'h0000, 1'b1);
    rd(UPX_IDX_STATUS, 16'h00ff, 1'b1);
    cmp16("drv_reads", 16'h0000, 16'(n_rd));
    $display("test reset_disable done");
    for (int k = 0; k < 4; k++)
    begin
      rd_code = rcodes[k];
      dly = 4'($urandom_range(0, 6));
      tgt = 16'($urandom_range(1, 65535));
      wr(UPX_IDX_TARGET, tgt);
      exp_param = tgt;
      rd(UPX_IDX_VALUE, 16'h0000, 1'b1);
      rd(UPX_IDX_STATUS, 16'h00ff, 1'b1);
      poll(UPX_RD_LSB, b);
      rd(UPX_IDX_STATUS, {8'h00, rcodes[k]}, 1'b1);
      rd(UPX_IDX_TARGET, tgt, 1'b1);
      n = n_rd;
      repeat (40) @(negedge clk);
      cmp16("rd_retry", 16'h0001, 16'(n_rd > n + 2));
      rd(UPX_IDX_VALUE, (k == 3) ? exp_v : 16'h0000, 1'b1);
      $display("test read code %h done", rcodes[k]);
    end
    for (int k = 0; k < 5; k++)
    begin
      wr_code = wcodes[k];
      v = 16'($urandom());
      n = n_wr;
      wr(UPX_IDX_VALUE, v);
      exp_wdata = v;
      rd(UPX_IDX_STATUS, 16'hff00, 1'b1);
      poll(UPX_WR_LSB, b);
      rd(UPX_IDX_STATUS, {wcodes[k], 8'h00}, 1'b1);
      if (wcodes[k] == 8'h00)
        exp_v = v;
      repeat (40) @(negedge clk);
      rd(UPX_IDX_STATUS, {wcodes[k], 8'h00}, 1'b1);
      rd(UPX_IDX_VALUE, exp_v, 1'b1);
      cmp16("wr_count", 16'(n + 1), 16'(n_wr));
      $display("test write code %h done", wcodes[k]);
    end
    wr(UPX_IDX_TARGET, 16'h0000);
    exp_param = 16'h0000;
    rd(UPX_IDX_VALUE, 16'h0000, 1'b1);
    rd(UPX_IDX_STATUS, 16'h00ff, 1'b1);
    repeat (4) @(negedge clk);
    // every read request must have been answered by an rvalid; a second rvalid for the same read is not caught here
    cmp16("notes_left", 16'h0000, 16'(notes.size()));
    $display("test disable done");
    print_verdict();
  end
endmodule
`default_nettype wire
